// file: fcr_device.sv
// Module: converter end, sequencing conversions and presenting results
`default_nettype none
// What this block does
// - host picks internal or external clock
// - host holds convert start low minimum time
// - sample all channels on convert start rise
// - pulse result ready per readable result
// - last ready falls with final result ready
// - host gives external clock within limits
// - external: first at cycle 17, then every 3
// - internal: first about 3.4us, then 600ns
// - host chip select style is free
// - drive bus while read and select low, else release
// - host waits next ready before next read
// - host waits three quiet cycles before start
// - external: last ready at pulse 26
// - each read pulse advances to next result, up to the fourth
// - host frees bus and waits quiet time
// - results are 14-bit two's complement
// - trim offset limited to 64 codes
// - data released when read or select high
// - tracking resumes after cycle 12
// - external clock 1 to 6 MHz
module fcr_device #(
  parameter int RESULT_WIDTH = fcr_pkg::RESULT_WIDTH,
  parameter logic signed [7:0] TRIM_OFFSET = 8'sh00
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Analogue samples, one word per channel
  input wire logic [4*RESULT_WIDTH-1:0] i_sample,
  // Link to host
  fcr_bus_if.device bus,
  // Status
  output logic o_tracking,
  output logic o_busy
);
  if (RESULT_WIDTH != fcr_pkg::RESULT_WIDTH)
  begin : g_width_check
    $error("Result width must be 14");
  end
  if (TRIM_OFFSET > 8'sh40 || TRIM_OFFSET < -8'sh40)
  begin : g_trim_check
    $error("Trim offset exceeds 64 codes");
  end
  // ***********************************************************************
  // State
  // ***********************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_DONE} fcr_phase_type;
  typedef struct packed {
    logic [2:0] cvs_sync;
    logic [2:0] clk_sync;
    logic [2:0] rd_sync;
    logic [2:0] cs_sync;
    logic [2:0] sel_sync;
    logic cvs;
    logic cclk;
    logic rd;
    fcr_phase_type phase;
    logic internal;
    logic [4:0] osc_count;
    logic [5:0] conv_cycle;
    logic [2:0] ready_count;
    logic [2:0] read_index;
    logic [3:0][13:0] held;
    logic result_ready_n;
    logic last_ready_n;
    logic [13:0] data_out;
    logic data_oe;
    logic tracking;
    logic [1:0] pulse_left;
    logic busy;
  } fcr_dev_state_type;
  fcr_dev_state_type state;
  fcr_dev_state_type next_state;
  logic [3:0][13:0] trimmed;
  // ***********************************************************************
  // Digital trim per channel
  // ***********************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_trim
      logic signed [14:0] sum;
      // One spare bit so a shifted code clamps at full scale instead of wrapping to the other sign
      assign sum = 15'($signed(i_sample[ch*14 +: 14])) + 15'(TRIM_OFFSET);
      assign trimmed[ch] = (sum > 15'sh1FFF) ? fcr_pkg::CODE_FULL_POSITIVE :
        (sum < -15'sh2000) ? fcr_pkg::CODE_FULL_NEGATIVE : sum[13:0];
    end
  endgenerate
  // ***********************************************************************
  // Next state
  // ***********************************************************************
  always_comb
  begin
    logic tick;
    logic rd_low;
    next_state = state;
    tick = 1'b0;
    rd_low = 1'b0;
    next_state.cvs_sync = {state.cvs_sync[1:0], bus.convert_start_n};
    next_state.clk_sync = {state.clk_sync[1:0], bus.conversion_clk};
    next_state.rd_sync = {state.rd_sync[1:0], bus.read_strobe_n};
    next_state.cs_sync = {state.cs_sync[1:0], bus.chip_select_n};
    next_state.sel_sync = {state.sel_sync[1:0], bus.clock_source_select};
    // A change counts only once the second and third stages agree
    if (state.cvs_sync[1] == state.cvs_sync[2])
      next_state.cvs = state.cvs_sync[2];
    if (state.clk_sync[1] == state.clk_sync[2])
      next_state.cclk = state.clk_sync[2];
    if (state.rd_sync[1] == state.rd_sync[2])
      next_state.rd = state.rd_sync[2];
    next_state.result_ready_n = 1'b1;
    next_state.last_ready_n = 1'b1;
    // A one-cycle strobe would never pass the host's agreeing synchroniser stages
    if (state.pulse_left != 2'h0)
    begin
      next_state.result_ready_n = 1'b0;
      next_state.last_ready_n = state.last_ready_n;
      next_state.pulse_left = state.pulse_left - 2'h1;
    end
    // Conversion clock edge, from the oscillator or the external pin
    if (state.internal)
    begin
      if (state.osc_count == 5'(fcr_pkg::INTERNAL_OSC_CYCLES - 1))
      begin
        next_state.osc_count = '0;
        tick = 1'b1;
      end
      else
        next_state.osc_count = state.osc_count + 5'd1;
    end
    else
      tick = next_state.cclk && !state.cclk;
    unique case (state.phase)
      ST_IDLE, ST_DONE:
      begin
        next_state.tracking = 1'b1;
        if (next_state.cvs && !state.cvs)
        begin
          next_state.held = trimmed;
          next_state.tracking = 1'b0;
          next_state.phase = ST_CONVERT;
          next_state.internal = state.sel_sync[2];
          next_state.osc_count = '0;
          next_state.conv_cycle = '0;
          next_state.ready_count = '0;
          next_state.read_index = '0;
        end
      end
      ST_CONVERT:
      begin
        if (tick)
        begin
          next_state.conv_cycle = state.conv_cycle + 6'd1;
          if (state.conv_cycle + 6'd1 > 6'(fcr_pkg::TRACK_RESUME_CYCLE))
            next_state.tracking = 1'b1;
          // Cycles 17, 20, 23, 26 make results readable
          if (state.conv_cycle + 6'd1 >= 6'(fcr_pkg::FIRST_RESULT_CYCLE) &&
              state.ready_count < 3'd4 &&
              state.conv_cycle + 6'd1 == 6'(fcr_pkg::FIRST_RESULT_CYCLE) +
              6'(fcr_pkg::RESULT_SPACING_CYCLES) * 6'(state.ready_count))
          begin
            next_state.result_ready_n = 1'b0;
            next_state.pulse_left = 2'(fcr_pkg::READY_PULSE_CYCLES - 1);
            next_state.ready_count = state.ready_count + 3'd1;
            if (state.ready_count == 3'd3)
            begin
              next_state.last_ready_n = 1'b0;
              next_state.phase = ST_DONE;
            end
          end
        end
      end
      default:
        next_state.phase = ST_IDLE;
    endcase
    next_state.busy = (next_state.phase == ST_CONVERT);
    // Each completed read strobe advances to the next channel, up to channel 3
    if (next_state.rd && !state.rd && state.read_index < 3'd3)
      next_state.read_index = state.read_index + 3'd1;
    rd_low = !state.rd_sync[2] && !state.rd_sync[1] && !state.cs_sync[2] && !state.cs_sync[1];
    next_state.data_oe = rd_low;
    next_state.data_out = state.held[state.read_index[1:0]];
  end
  // ***********************************************************************
  // Registers
  // ***********************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= '0;
      state.cvs_sync <= 3'h7;
      state.clk_sync <= 3'h0;
      state.rd_sync <= 3'h7;
      state.cs_sync <= 3'h7;
      state.cvs <= 1'b1;
      state.rd <= 1'b1;
      state.phase <= ST_IDLE;
      state.result_ready_n <= 1'b1;
      state.last_ready_n <= 1'b1;
      state.tracking <= 1'b1;
    end
    else if (i_clk_en)
      state <= next_state;
  end
  assign bus.result_ready_n = state.result_ready_n;
  assign bus.last_result_ready_n = state.last_ready_n;
  assign bus.data_out = state.data_out;
  assign bus.data_oe = state.data_oe;
  assign o_tracking = state.tracking;
  assign o_busy = state.busy;
endmodule : fcr_device
`default_nettype wire

// file: fcr_pkg.sv
// Package: shared constants for the four channel conversion readout
`default_nettype none
package fcr_pkg;
  // ***********************************************************************
  // Widths and counts
  // ***********************************************************************
  localparam int RESULT_WIDTH = 14;
  localparam int CHANNEL_COUNT = 4;
  localparam int CORE_CLOCK_MHZ = 125;
  // ***********************************************************************
  // Conversion clock timing, in conversion clock cycles
  // ***********************************************************************
  localparam int FIRST_RESULT_CYCLE = 17;
  localparam int RESULT_SPACING_CYCLES = 3;
  localparam int LAST_RESULT_CYCLE = 26;
  localparam int TRACK_RESUME_CYCLE = 12;
  localparam int QUIET_CYCLES = 3;
  // ***********************************************************************
  // Internal oscillator and core clock timing
  // ***********************************************************************
  localparam int INTERNAL_OSC_NS = 200;
  localparam int INTERNAL_OSC_CYCLES = (INTERNAL_OSC_NS * CORE_CLOCK_MHZ) / 1000;
  localparam int FIRST_RESULT_NS = 3400;
  localparam int NEXT_RESULT_NS = 600;
  localparam int CONVERT_PULSE_MIN_NS = 40;
  localparam int CONVERT_PULSE_MIN_CYCLES = (CONVERT_PULSE_MIN_NS * CORE_CLOCK_MHZ + 999) / 1000;
  localparam int EXT_CLOCK_HALF_NS = 200;
  localparam int EXT_CLOCK_HALF_CYCLES = (EXT_CLOCK_HALF_NS * CORE_CLOCK_MHZ) / 1000;
  // Quiet time at the host's own conversion clock; also longer than three oscillator periods
  localparam int QUIET_CORE_CYCLES = QUIET_CYCLES * 2 * EXT_CLOCK_HALF_CYCLES;
  // Ready strobes outlast the host's agreeing synchroniser stages
  localparam int READY_PULSE_CYCLES = 4;
  // ***********************************************************************
  // Code values
  // ***********************************************************************
  localparam logic [13:0] CODE_FULL_POSITIVE = 14'h1FFF;
  localparam logic [13:0] CODE_FULL_NEGATIVE = 14'h2000;
  localparam logic [13:0] CODE_ZERO = 14'h0000;
  localparam int TRIM_LIMIT = 64;
endpackage : fcr_pkg
`default_nettype wire

// file: fcr_bus_if.sv
// Interface: pins between converter and host
`default_nettype none
interface fcr_bus_if;
  logic clock_source_select;
  logic convert_start_n;
  logic conversion_clk;
  logic chip_select_n;
  logic read_strobe_n;
  logic result_ready_n;
  logic last_result_ready_n;
  logic [13:0] data_out;
  logic data_oe;
  logic [13:0] data;
  // No pull on these lines: a released bus shows the inverse so a late capture is caught
  assign data = data_oe ? data_out : ~data_out;
  modport device (
    input clock_source_select, convert_start_n, conversion_clk, chip_select_n, read_strobe_n,
    output result_ready_n, last_result_ready_n, data_out, data_oe
  );
  modport host (
    output clock_source_select, convert_start_n, conversion_clk, chip_select_n, read_strobe_n,
    input result_ready_n, last_result_ready_n, data
  );
endinterface : fcr_bus_if
`default_nettype wire

// file: fcr_host.sv
// Module: host end, starting conversions and reading four results
`default_nettype none
module fcr_host (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // User side
  input wire logic i_start,
  input wire logic i_use_internal,
  output logic o_busy,
  output logic o_result_valid,
  output logic [1:0] o_result_channel,
  output logic [13:0] o_result,
  // Link to converter
  fcr_bus_if.host bus
);
  // ***********************************************************************
  // State
  // ***********************************************************************
  typedef enum logic [2:0] {HS_IDLE, HS_PULSE, HS_WAIT, HS_READ, HS_QUIET} fcr_host_phase_type;
  typedef struct packed {
    logic [2:0] rdy_sync;
    logic rdy;
    fcr_host_phase_type phase;
    logic internal;
    logic cvs_n;
    logic cs_n;
    logic rd_n;
    logic cclk;
    logic [5:0] half_count;
    logic [7:0] count;
    logic [2:0] channel;
    logic [2:0] pending;
    logic valid;
    logic [13:0] result;
    logic [1:0] result_channel;
    logic busy;
  } fcr_host_state_type;
  fcr_host_state_type state;
  fcr_host_state_type next_state;
  always_comb
  begin
    next_state = state;
    next_state.valid = 1'b0;
    next_state.rdy_sync = {state.rdy_sync[1:0], bus.result_ready_n};
    if (state.rdy_sync[1] == state.rdy_sync[2])
      next_state.rdy = state.rdy_sync[2];
    // Free running conversion clock of 2.5 MHz, inside the legal external range
    if (!state.internal)
    begin
      if (state.half_count == 6'(fcr_pkg::EXT_CLOCK_HALF_CYCLES - 1))
      begin
        next_state.half_count = '0;
        next_state.cclk = !state.cclk;
      end
      else
        next_state.half_count = state.half_count + 6'd1;
    end
    // Count readiness pulses so no read outruns its result
    if (!next_state.rdy && state.rdy)
      next_state.pending = state.pending + 3'd1;
    unique case (state.phase)
      HS_IDLE:
        if (i_start)
        begin
          next_state.internal = i_use_internal;
          next_state.cvs_n = 1'b0;
          next_state.count = '0;
          next_state.channel = '0;
          next_state.pending = '0;
          next_state.phase = HS_PULSE;
        end
      HS_PULSE:
      begin
        // Pulse held several cycles beyond the minimum to cover pin sampling
        next_state.count = state.count + 8'h01;
        if (state.count == 8'(fcr_pkg::CONVERT_PULSE_MIN_CYCLES + 7))
        begin
          next_state.cvs_n = 1'b1;
          next_state.count = '0;
          next_state.phase = HS_WAIT;
        end
      end
      HS_WAIT:
        if (state.pending != 3'd0)
        begin
          next_state.cs_n = 1'b0;
          next_state.rd_n = 1'b0;
          next_state.count = '0;
          next_state.phase = HS_READ;
        end
      HS_READ:
      begin
        next_state.count = state.count + 8'h01;
        // Capture with the strobe's rise, while the converter still drives the bus
        if (state.count == 8'h0C)
        begin
          next_state.rd_n = 1'b1;
          next_state.result = bus.data;
        end
        if (state.count == 8'h14)
        begin
          next_state.valid = 1'b1;
          next_state.result_channel = state.channel[1:0];
          next_state.pending = next_state.pending - 3'd1;
          next_state.channel = state.channel + 3'd1;
          next_state.count = '0;
          if (state.channel == 3'd3)
          begin
            next_state.cs_n = 1'b1;
            next_state.phase = HS_QUIET;
          end
          else
            next_state.phase = HS_WAIT;
        end
      end
      HS_QUIET:
      begin
        // Three periods of this end's conversion clock, counted after the last capture
        next_state.count = state.count + 8'h01;
        if (state.count == 8'(fcr_pkg::QUIET_CORE_CYCLES - 1))
          next_state.phase = HS_IDLE;
      end
      default:
        next_state.phase = HS_IDLE;
    endcase
    next_state.busy = (next_state.phase != HS_IDLE);
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= '0;
      state.rdy_sync <= 3'h7;
      state.rdy <= 1'b1;
      state.phase <= HS_IDLE;
      state.internal <= 1'b1;
      state.cvs_n <= 1'b1;
      state.cs_n <= 1'b1;
      state.rd_n <= 1'b1;
    end
    else if (i_clk_en)
      state <= next_state;
  end
  assign bus.clock_source_select = state.internal;
  assign bus.convert_start_n = state.cvs_n;
  assign bus.conversion_clk = state.cclk;
  assign bus.chip_select_n = state.cs_n;
  assign bus.read_strobe_n = state.rd_n;
  assign o_busy = state.busy;
  assign o_result_valid = state.valid;
  assign o_result_channel = state.result_channel;
  assign o_result = state.result;
endmodule : fcr_host
`default_nettype wire

// file: fcr_link_properties.sv
// Checker: timing and bus relations on the converter to host link
`default_nettype none
module fcr_link_properties (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Link signals
  input wire logic clock_source_select,
  input wire logic convert_start_n,
  input wire logic conversion_clk,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic result_ready_n,
  input wire logic last_result_ready_n,
  input wire logic [13:0] data_out,
  input wire logic data_oe,
  input wire logic [13:0] data
);
  // ***********************************************************************
  // Helper counters, restarted on each convert start rise
  // ***********************************************************************
  logic start_q;
  logic clk_q;
  logic ready_q;
  logic [15:0] since_start;
  logic [7:0] ext_edges;
  logic [2:0] ready_cnt;
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      start_q <= 1'b1;
      clk_q <= 1'b0;
      ready_q <= 1'b1;
      since_start <= 16'h0000;
      ext_edges <= 8'h00;
      ready_cnt <= 3'h0;
    end
    else
    begin
      start_q <= convert_start_n;
      clk_q <= conversion_clk;
      ready_q <= result_ready_n;
      if (convert_start_n && !start_q)
      begin
        since_start <= 16'h0000;
        ext_edges <= 8'h00;
        ready_cnt <= 3'h0;
      end
      else
      begin
        since_start <= since_start + 16'h0001;
        // Raw pin edges: the design's sync lag is far shorter than a clock period
        ext_edges <= ext_edges + 8'((conversion_clk && !clk_q) ? 1 : 0);
        // Counts strobes, not the cycles that each strobe stands
        ready_cnt <= ready_cnt + 3'((!result_ready_n && ready_q) ? 1 : 0);
      end
    end
  end
  // ***********************************************************************
  // Properties
  // ***********************************************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  ready_pulse_one_a: assert property ($fell(result_ready_n) |-> !result_ready_n [*4] ##1 result_ready_n)
    else $error("Ready pulse not four cycles wide");
  ready_count_max_a: assert property ($fell(result_ready_n) |-> ready_cnt < 3'h4)
    else $error("More than four ready pulses in one conversion");
  last_with_ready_a: assert property ($fell(last_result_ready_n) |-> $fell(result_ready_n) && ready_cnt == 3'h3)
    else $error("Last ready not with fourth ready pulse");
  ext_result_edge_a: assert property ($fell(result_ready_n) && !clock_source_select
    |-> ext_edges == 8'(17 + 3 * ready_cnt))
    else $error("External mode ready on wrong clock edge");
  ext_last_edge_a: assert property (!last_result_ready_n && !clock_source_select |-> ext_edges == 8'h1A)
    else $error("External mode last ready not on edge 26");
  int_first_ready_a: assert property ($fell(result_ready_n) && clock_source_select && ready_cnt == 3'h0
    |-> since_start >= 16'h018B && since_start <= 16'h01CC)
    else $error("Internal mode first ready out of window");
  int_ready_gap_a: assert property ($fell(result_ready_n) && clock_source_select && ready_cnt < 3'h3
    |-> ##[72:78] $fell(result_ready_n))
    else $error("Internal mode ready spacing wrong");
  data_release_a: assert property ((read_strobe_n || chip_select_n) [*6] |-> !data_oe)
    else $error("Data driven while released");
  data_drive_a: assert property ((!read_strobe_n && !chip_select_n) [*6] |-> data_oe)
    else $error("Data not driven during read");
  data_hold_a: assert property ((!read_strobe_n && !chip_select_n) [*8] |-> $stable(data_out))
    else $error("Data changed inside one read");
  int_first_c: cover property ($fell(result_ready_n) && clock_source_select);
  ext_last_c: cover property (!last_result_ready_n && !clock_source_select);
  read_c: cover property ($fell(read_strobe_n) && !chip_select_n);
endmodule : fcr_link_properties
`default_nettype wire

// file: four_channel_adc_conversion_readout_tb.sv
// Testbench: both ends joined, host results checked against driven samples
`default_nettype none
module four_channel_adc_conversion_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ***********************************************************************
  // Signals and instances
  // ***********************************************************************
  logic i_core_clk;
  logic i_rst_n;
  logic clk_en;
  logic start;
  logic use_int;
  logic [55:0] sample;
  logic tracking;
  logic dev_busy;
  logic host_busy;
  logic res_valid;
  logic [1:0] res_chan;
  logic [13:0] res;
  logic [15:0] exp_q[$];
  int error_cnt;
  int check_count;
  // A negative shift pushes the full negative code into the clamp
  localparam logic signed [7:0] TRIM_SHIFT = -8'sh28;
  fcr_bus_if fcr_bus_if_i ();
  fcr_device #(.TRIM_OFFSET(TRIM_SHIFT)) fcr_device_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_clk_en(clk_en),
    .i_sample(sample),
    .bus(fcr_bus_if_i), .o_tracking(tracking), .o_busy(dev_busy));
  fcr_host fcr_host_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_clk_en(clk_en), .i_start(start),
    .i_use_internal(use_int), .o_busy(host_busy), .o_result_valid(res_valid), .o_result_channel(res_chan),
    .o_result(res), .bus(fcr_bus_if_i));
  fcr_link_properties fcr_link_properties_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .clock_source_select(fcr_bus_if_i.clock_source_select), .convert_start_n(fcr_bus_if_i.convert_start_n),
    .conversion_clk(fcr_bus_if_i.conversion_clk), .chip_select_n(fcr_bus_if_i.chip_select_n),
    .read_strobe_n(fcr_bus_if_i.read_strobe_n), .result_ready_n(fcr_bus_if_i.result_ready_n),
    .last_result_ready_n(fcr_bus_if_i.last_result_ready_n), .data_out(fcr_bus_if_i.data_out),
    .data_oe(fcr_bus_if_i.data_oe), .data(fcr_bus_if_i.data));
  // ***********************************************************************
  // Tasks
  // ***********************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // Expected code: shifted by the trim and held at the full scale codes
  function automatic logic [13:0] trim_code(input logic [13:0] raw);
    int v;
    v = $signed(raw) + int'(TRIM_SHIFT);
    if (v > 8191)
      v = 8191;
    if (v < -8192)
      v = -8192;
    return 14'(v);
  endfunction : trim_code
  // One whole conversion; the stall freezes both ends together so the link stays legal
  task automatic run_conv(input logic mode, input logic [55:0] smp, input logic stall);
    int n;
    sample <= smp;
    use_int <= mode;
    start <= 1'b1;
    for (int c = 0; c < 4; c++)
      exp_q.push_back({2'(c), trim_code(smp[c*14 +: 14])});
    n = 0;
    while (host_busy !== 1'b1 && n < 100)
    begin
      @(posedge i_core_clk);
      n++;
    end
    start <= 1'b0;
    repeat (40) @(posedge i_core_clk);
    check({15'h0000, tracking}, 16'h0000);
    check({15'h0000, dev_busy}, 16'h0001);
    sample <= 56'({$urandom(), $urandom()});
    if (stall)
    begin
      repeat (20) @(posedge i_core_clk);
      clk_en <= 1'b0;
      repeat (10) @(posedge i_core_clk);
      clk_en <= 1'b1;
    end
    n = 0;
    while (host_busy !== 1'b0 && n < 6000)
    begin
      @(posedge i_core_clk);
      n++;
    end
    repeat (2) @(posedge i_core_clk);
    check({15'h0000, tracking}, 16'h0001);
    check({15'h0000, dev_busy}, 16'h0000);
  endtask : run_conv
  // ***********************************************************************
  // Clock, stimulus, monitor and watchdog
  // ***********************************************************************
  initial
  begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  initial
  begin
    i_rst_n = 1'b0;
    clk_en = 1'b1;
    start = 1'b0;
    use_int = 1'b0;
    sample = '0;
    error_cnt = 0;
    check_count = 0;
    void'($urandom(32'h3BD4));
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    // Alternate clock sources; pass 1 carries the code extremes
    for (int i = 0; i < 4; i++)
      run_conv(i[0], (i == 1) ? {14'h2000, 14'h3FFF, 14'h0000, 14'h1FFF} : 56'({$urandom(), $urandom()}),
        i == 2);
    repeat (10) @(posedge i_core_clk);
    check(16'(exp_q.size()), 16'h0000);
    complete_run();
  end
  // Falling edge sampling keeps the one-cycle valid pulse clear of update races
  always @(negedge i_core_clk)
  begin
    if (res_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check({res_chan, res}, ~{res_chan, res});
      else
        check({res_chan, res}, exp_q.pop_front());
    end
  end
  initial
  begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule : four_channel_adc_conversion_readout_tb
`default_nettype wire
